// [rtl/serial_port_pkg.sv]
// constants, modes and state encodings shared by the serial port files
package serial_port_pkg;
	// ------------------------------------------------------------
	// operating modes
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_SHIFT = 2'h0;
	localparam logic [1:0] MODE_8BIT = 2'h1;
	localparam logic [1:0] MODE_9FIX = 2'h2;
	localparam logic [1:0] MODE_9VAR = 2'h3;
	// ------------------------------------------------------------
	// bit timing: 16 oversample ticks per bit, shift mode /16
	// ------------------------------------------------------------
	localparam logic [3:0] OS_LAST = 4'hF;
	localparam logic [3:0] OS_MID = 4'h7;
	localparam logic [3:0] SH_LAST = 4'hF;
	localparam logic [3:0] SH_SAMPLE = 4'h8;
	// ------------------------------------------------------------
	// frame lengths in bits and the broadcast address
	// ------------------------------------------------------------
	localparam logic [3:0] TX_BITS_8 = 4'hA;
	localparam logic [3:0] TX_BITS_9 = 4'hB;
	localparam logic [3:0] SH_BITS = 4'h8;
	localparam logic [3:0] RX_BITS_8 = 4'h8;
	localparam logic [3:0] RX_BITS_9 = 4'h9;
	localparam logic [7:0] BROADCAST_ADDR = 8'hFF;
	// ------------------------------------------------------------
	// state machines
	// ------------------------------------------------------------
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_ASYNC = 2'b01, TX_SYNC = 2'b10} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10,
		RX_SYNC = 2'b11} rx_state_t;
endpackage

// [rtl/baud_rate_gen.sv]
// independent baud generator counting oscillator ticks
`timescale 1ns/1ps
module baud_rate_gen #(
	parameter int DIV_W = 16
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	// oscillator tick and divisor
	input wire logic osc_tick,
	input wire logic [DIV_W/2-1:0] baud_divisor_high,
	input wire logic [DIV_W/2-1:0] baud_divisor_low,
	// one tick per divisor+1 oscillator ticks
	output logic brg_tick
);
	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] divisor;
	logic wrap;

	// ------------------------------------------------------------
	// divider
	// ------------------------------------------------------------
	assign divisor = {baud_divisor_high, baud_divisor_low};
	assign wrap = osc_tick && (cnt_q >= divisor);

	// counts oscillator ticks only, so the processor clock rate does not matter
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= '0;
			brg_tick <= 1'b0;
		end else if (clk_en) begin
			brg_tick <= wrap;
			if (wrap) begin
				cnt_q <= '0;
			end else if (osc_tick) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_brg_reload;
		@(posedge mclk) disable iff (!reset_n) (clk_en && wrap) |=> (brg_tick && cnt_q == '0);
	endproperty
	a_brg_reload: assert property (p_brg_reload) else $error("generator did not reload");
	property p_brg_osc;
		@(posedge mclk) disable iff (!reset_n) (clk_en && !osc_tick) |=> !brg_tick;
	endproperty
	a_brg_osc: assert property (p_brg_osc) else $error("tick without oscillator");
	c_brg_tick: cover property (@(posedge mclk) disable iff (!reset_n) brg_tick);
endmodule

// [rtl/serial_port.sv]
// enhanced serial port: shift mode, 8-bit and 9-bit framed modes
// Summary of operation
// - Shift mode moves 8 bits LSB first on the data pin while the other pin carries the clock.
// - Shift mode runs at one sixteenth of the processor clock regardless of baud settings.
// - The 8-bit mode frame is a low start bit, eight data bits LSB first and a high stop bit.
// - In the 8-bit mode the received stop bit is stored in the receive ninth-bit flag.
// - The 8-bit mode rate comes from timer 1 overflow or from the baud generator.
// - The 9-bit frame is start, eight data bits LSB first, the transmit ninth bit and stop.
// - In 9-bit modes the received ninth bit goes to the flag and the stop bit is discarded.
// - The fixed 9-bit mode runs at 1/16 or 1/32 of the processor clock by the doubling bit.
// - The variable 9-bit mode equals the fixed one but takes timer 1 or generator rate.
// - The generator divides by one more than the 16-bit divisor built from the high and low divisor bytes.
// - The generator is clocked from the oscillator, not from the processor clock.
// - A timer 1 overflow source is halved again while the doubling bit is set.
// - Only the divided clock, timer 1 overflow or the generator can set the rate.
// - The port offers framing errors, address recognition, double buffering and events.
// - A break can request a chip reset, recorded in a cause flag.
`timescale 1ns/1ps
module serial_port #(
	parameter int DIV_W = 16
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	// rate sources
	input wire logic osc_tick,
	input wire logic t1_overflow,
	// configuration
	input wire logic [1:0] mode,
	input wire logic rx_enable,
	input wire logic baud_double_select,
	input wire logic brg_select,
	input wire logic [DIV_W/2-1:0] baud_divisor_high,
	input wire logic [DIV_W/2-1:0] baud_divisor_low,
	input wire logic addr_match_en,
	input wire logic [7:0] own_addr,
	input wire logic double_buffer_en,
	input wire logic break_reset_en,
	// transmit request
	input wire logic [7:0] tx_data,
	input wire logic tx_ninth_bit,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic tx_done,
	// receive results
	input wire logic shift_rx_start,
	output logic [7:0] rx_data,
	output logic rx_ninth_bit,
	output logic rx_frame_err,
	output logic rx_valid,
	// sticky status flags and the one-cycle break request
	input wire logic framing_error_clear,
	output logic framing_error,
	input wire logic break_cause_clear,
	output logic reset_cause_break,
	output logic break_reset_req,
	// pins
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe,
	output logic txd_out
);
	serial_port_pkg::tx_state_t tx_st_q;
	serial_port_pkg::rx_state_t rx_st_q;
	logic brg_tick, os_tick, m2_div_q, t1_half_q, nine;
	logic [3:0] sh_cnt_q, tx_os_q, tx_left_q, rx_os_q, rx_left_q;
	logic [10:0] tx_sr_q;
	logic [8:0] rx_sr_q;
	logic hold_q, hold_ninth_q;
	logic [7:0] hold_data_q;
	logic [7:0] fr_data;
	logic fr_ninth, fr_end, fr_stop, fr_brk, deliver, sh_end;

	baud_rate_gen #(.DIV_W(DIV_W)) u_brg (
		.mclk(mclk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.osc_tick(osc_tick),
		.baud_divisor_high(baud_divisor_high),
		.baud_divisor_low(baud_divisor_low),
		.brg_tick(brg_tick)
	);

	// ------------------------------------------------------------
	// rate selection: oversample tick at 16 per bit
	// ------------------------------------------------------------
	// no timer 2 input exists, so it can never be picked as a source
	always_comb begin
		nine = mode[1];
		unique case (mode)
			serial_port_pkg::MODE_9FIX: os_tick = clk_en && (baud_double_select || m2_div_q);
			serial_port_pkg::MODE_8BIT, serial_port_pkg::MODE_9VAR:
				os_tick = clk_en && (brg_select ? brg_tick
					: (t1_overflow && (!baud_double_select || t1_half_q)));
			default: os_tick = 1'b0;
		endcase
	end

	// prescalers for the fixed mode and the halved timer source
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			m2_div_q <= 1'b0;
			t1_half_q <= 1'b0;
		end else if (clk_en) begin
			m2_div_q <= !m2_div_q;
			if (t1_overflow) begin
				t1_half_q <= !t1_half_q;
			end
		end
	end

	// shift mode clock: low half then high half, 16 processor clocks per bit
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sh_cnt_q <= '0;
		end else if (clk_en) begin
			if (tx_st_q == serial_port_pkg::TX_SYNC || rx_st_q == serial_port_pkg::RX_SYNC) begin
				sh_cnt_q <= sh_cnt_q + 1'b1;
			end else begin
				sh_cnt_q <= '0;
			end
		end
	end
	assign sh_end = clk_en && sh_cnt_q == serial_port_pkg::SH_LAST;

	// ------------------------------------------------------------
	// transmit: optional holding register in front of the shifter
	// ------------------------------------------------------------
	// with double buffering off the next byte waits until the line is idle
	assign tx_ready = !hold_q && (double_buffer_en || tx_st_q == serial_port_pkg::TX_IDLE);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hold_q <= 1'b0;
			hold_data_q <= '0;
			hold_ninth_q <= 1'b0;
		end else if (clk_en) begin
			if (tx_valid && tx_ready) begin
				hold_q <= 1'b1;
				hold_data_q <= tx_data;
				hold_ninth_q <= tx_ninth_bit;
			end else if (tx_st_q == serial_port_pkg::TX_IDLE && rx_st_q != serial_port_pkg::RX_SYNC) begin
				hold_q <= 1'b0;
			end
		end
	end

	// frame shifter; shifts right with ones filling so the line rests high
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_st_q <= serial_port_pkg::TX_IDLE;
			tx_sr_q <= '1;
			tx_os_q <= '0;
			tx_left_q <= '0;
			tx_done <= 1'b0;
		end else if (clk_en) begin
			tx_done <= 1'b0;
			unique case (tx_st_q)
				serial_port_pkg::TX_IDLE: begin
					tx_os_q <= '0;
					if (hold_q && mode == serial_port_pkg::MODE_SHIFT
							&& rx_st_q != serial_port_pkg::RX_SYNC) begin
						tx_st_q <= serial_port_pkg::TX_SYNC;
						tx_sr_q <= {3'b111, hold_data_q};
						tx_left_q <= serial_port_pkg::SH_BITS;
					end else if (hold_q && mode != serial_port_pkg::MODE_SHIFT) begin
						tx_st_q <= serial_port_pkg::TX_ASYNC;
						tx_sr_q <= {1'b1, nine ? hold_ninth_q : 1'b1, hold_data_q, 1'b0};
						tx_left_q <= nine ? serial_port_pkg::TX_BITS_9 : serial_port_pkg::TX_BITS_8;
					end
				end
				serial_port_pkg::TX_ASYNC: begin
					if (os_tick) begin
						tx_os_q <= tx_os_q + 1'b1;
						if (tx_os_q == serial_port_pkg::OS_LAST) begin
							tx_sr_q <= {1'b1, tx_sr_q[10:1]};
							tx_left_q <= tx_left_q - 1'b1;
							if (tx_left_q == 4'h1) begin
								tx_st_q <= serial_port_pkg::TX_IDLE;
								tx_done <= 1'b1;
							end
						end
					end
				end
				serial_port_pkg::TX_SYNC: begin
					if (sh_end) begin
						tx_sr_q <= {1'b1, tx_sr_q[10:1]};
						tx_left_q <= tx_left_q - 1'b1;
						if (tx_left_q == 4'h1) begin
							tx_st_q <= serial_port_pkg::TX_IDLE;
							tx_done <= 1'b1;
						end
					end
				end
				default: tx_st_q <= serial_port_pkg::TX_IDLE;
			endcase
		end
	end

	// pins: shift mode drives data on the receive pin and the clock on the transmit pin
	assign rxd_oe = tx_st_q == serial_port_pkg::TX_SYNC;
	assign rxd_out = tx_sr_q[0];
	assign txd_out = (tx_st_q == serial_port_pkg::TX_ASYNC) ? tx_sr_q[0]
		: ((tx_st_q == serial_port_pkg::TX_SYNC || rx_st_q == serial_port_pkg::RX_SYNC)
			? sh_cnt_q[3] : 1'b1);

	// ------------------------------------------------------------
	// receive: start found on a low sample, then mid-bit sampling
	// ------------------------------------------------------------
	assign fr_data = (nine && rx_st_q != serial_port_pkg::RX_SYNC) ? rx_sr_q[7:0] : rx_sr_q[8:1];
	assign fr_ninth = nine ? rx_sr_q[8] : rxd_in;
	assign fr_stop = rxd_in;
	assign fr_end = rx_st_q == serial_port_pkg::RX_DATA && os_tick
		&& rx_os_q == serial_port_pkg::OS_LAST && rx_left_q == '0;
	assign fr_brk = fr_end && !fr_stop && fr_data == '0 && !(nine && rx_sr_q[8]);
	// address filter: a 9-bit frame passes only as a matching or broadcast address
	always_comb begin
		deliver = 1'b1;
		if (addr_match_en) begin
			deliver = nine ? (fr_ninth && (fr_data == own_addr
				|| fr_data == serial_port_pkg::BROADCAST_ADDR)) : fr_stop;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rx_st_q <= serial_port_pkg::RX_IDLE;
			rx_os_q <= '0;
			rx_left_q <= '0;
			rx_sr_q <= '0;
		end else if (clk_en) begin
			unique case (rx_st_q)
				serial_port_pkg::RX_IDLE: begin
					rx_os_q <= '0;
					if (mode == serial_port_pkg::MODE_SHIFT) begin
						if (shift_rx_start && rx_enable && tx_st_q == serial_port_pkg::TX_IDLE
								&& !hold_q) begin
							rx_st_q <= serial_port_pkg::RX_SYNC;
							rx_left_q <= serial_port_pkg::SH_BITS;
						end
					end else if (rx_enable && os_tick && !rxd_in) begin
						rx_st_q <= serial_port_pkg::RX_START;
					end
				end
				serial_port_pkg::RX_START: begin
					if (os_tick) begin
						rx_os_q <= rx_os_q + 1'b1;
						if (rx_os_q == serial_port_pkg::OS_MID) begin
							rx_os_q <= '0;
							rx_left_q <= nine ? serial_port_pkg::RX_BITS_9 : serial_port_pkg::RX_BITS_8;
							rx_st_q <= rxd_in ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
						end
					end
				end
				serial_port_pkg::RX_DATA: begin
					if (os_tick) begin
						rx_os_q <= rx_os_q + 1'b1;
						if (rx_os_q == serial_port_pkg::OS_LAST) begin
							if (rx_left_q == '0) begin
								rx_st_q <= serial_port_pkg::RX_IDLE; // stop bit not shifted in
							end else begin
								rx_sr_q <= {rxd_in, rx_sr_q[8:1]};
								rx_left_q <= rx_left_q - 1'b1;
							end
						end
					end
				end
				serial_port_pkg::RX_SYNC: begin
					if (clk_en && sh_cnt_q == serial_port_pkg::SH_SAMPLE) begin
						rx_sr_q <= {rxd_in, rx_sr_q[8:1]};
						rx_left_q <= rx_left_q - 1'b1;
					end
					if (sh_end && rx_left_q == '0) begin
						rx_st_q <= serial_port_pkg::RX_IDLE;
					end
				end
				default: rx_st_q <= serial_port_pkg::RX_IDLE;
			endcase
		end
	end

	// results, error and break flags; a set in the clearing cycle wins
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rx_data <= '0;
			rx_ninth_bit <= 1'b0;
			rx_frame_err <= 1'b0;
			rx_valid <= 1'b0;
			framing_error <= 1'b0;
			reset_cause_break <= 1'b0;
			break_reset_req <= 1'b0;
		end else if (clk_en) begin
			rx_valid <= 1'b0;
			break_reset_req <= fr_brk && break_reset_en;
			if (fr_end && deliver) begin
				rx_data <= fr_data;
				rx_ninth_bit <= fr_ninth;
				rx_frame_err <= !fr_stop;
				rx_valid <= 1'b1;
			end else if (rx_st_q == serial_port_pkg::RX_SYNC && sh_end && rx_left_q == '0) begin
				rx_data <= fr_data;
				rx_valid <= 1'b1;
			end
			if (fr_end && !fr_stop) begin
				framing_error <= 1'b1;
			end else if (framing_error_clear) begin
				framing_error <= 1'b0;
			end
			if (fr_brk && break_reset_en) begin
				reset_cause_break <= 1'b1;
			end else if (break_cause_clear) begin
				reset_cause_break <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_sh_drive;
		@(posedge mclk) disable iff (!reset_n)
			(tx_st_q == serial_port_pkg::TX_SYNC) |-> (rxd_oe && txd_out == sh_cnt_q[3]);
	endproperty
	a_sh_drive: assert property (p_sh_drive) else $error("shift mode pins wrong");
	// a bit may only advance when the 16-count shift clock has just wrapped
	property p_sh_rate;
		@(posedge mclk) disable iff (!reset_n)
			(tx_st_q == serial_port_pkg::TX_SYNC && $past(tx_st_q) == serial_port_pkg::TX_SYNC
			&& $changed(tx_left_q)) |-> $past(sh_cnt_q) == serial_port_pkg::SH_LAST;
	endproperty
	a_sh_rate: assert property (p_sh_rate) else $error("shift bit not 16 clocks");
	property p_start_low;
		@(posedge mclk) disable iff (!reset_n)
			(clk_en && tx_st_q == serial_port_pkg::TX_IDLE && hold_q && mode != 2'h0)
			|=> (!txd_out && tx_st_q == serial_port_pkg::TX_ASYNC);
	endproperty
	a_start_low: assert property (p_start_low) else $error("no start bit");
	property p_ninth_out;
		@(posedge mclk) disable iff (!reset_n)
			(clk_en && tx_st_q == serial_port_pkg::TX_IDLE && hold_q && nine)
			|=> tx_sr_q[9] == $past(hold_ninth_q);
	endproperty
	a_ninth_out: assert property (p_ninth_out) else $error("ninth bit slot wrong");
	property p_stop_flag;
		@(posedge mclk) disable iff (!reset_n)
			(rx_valid && mode == serial_port_pkg::MODE_8BIT) |-> rx_ninth_bit == !rx_frame_err;
	endproperty
	a_stop_flag: assert property (p_stop_flag) else $error("stop bit not stored");
	property p_fix_rate;
		@(posedge mclk) disable iff (!reset_n)
			(clk_en && mode == serial_port_pkg::MODE_9FIX && !baud_double_select && os_tick)
			##1 clk_en |-> (!os_tick || mode != serial_port_pkg::MODE_9FIX || baud_double_select);
	endproperty
	a_fix_rate: assert property (p_fix_rate) else $error("fixed rate not halved");
	property p_t1_half;
		@(posedge mclk) disable iff (!reset_n)
			(os_tick && mode[0] && !brg_select) |->
				(t1_overflow && (!baud_double_select || t1_half_q));
	endproperty
	a_t1_half: assert property (p_t1_half) else $error("timer source not halved");
	property p_frame_err;
		@(posedge mclk) disable iff (!reset_n)
			(clk_en && fr_end && !fr_stop) |=> framing_error;
	endproperty
	a_frame_err: assert property (p_frame_err) else $error("framing error missed");
	property p_break;
		@(posedge mclk) disable iff (!reset_n)
			break_reset_req |-> (reset_cause_break && $past(fr_brk));
	endproperty
	a_break: assert property (p_break) else $error("break reset not recorded");
	c_tx_frame: cover property (@(posedge mclk) disable iff (!reset_n) tx_done && mode[1]);
	c_rx_frame: cover property (@(posedge mclk) disable iff (!reset_n) rx_valid && mode[0]);
	c_break: cover property (@(posedge mclk) disable iff (!reset_n) break_reset_req);
endmodule

// [verification/serial_peer.sv]
// remote serial peer: async frames both ways and a shift-register device
`timescale 1ns/1ps
module serial_peer (
	// clock
	input wire logic mclk,
	// pins as seen from the far side
	input wire logic txd,
	input wire logic line,
	output logic drv_oe,
	output logic drv_val
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// released at start: the pull-up holds the line high
	initial begin
		drv_oe = 1'b0;
		drv_val = 1'b1;
	end
	// samples land after the design's edge updates have settled
	task automatic step(input int n);
		repeat (n) begin
			@(posedge mclk);
			#2;
		end
	endtask
	// bounded wait for a level on txd; waited counts the cycles spent
	task automatic wait_txd(input logic v, input int lim, output int waited);
		waited = 0;
		while (txd !== v && waited < lim) begin
			step(1);
			waited++;
		end
	endtask
	// ------------------------------------------------------------
	// async frames
	// ------------------------------------------------------------
	// mid-bit sampling, so a wrong bit period scrambles the capture
	task automatic get_frame(input int bit_cyc, input int nbits, output logic [10:0] bits);
		int w;
		bits = 11'h7FF;
		wait_txd(1'b0, 3000, w);
		step(bit_cyc / 2);
		for (int i = 0; i < nbits; i++) begin
			bits[i] = txd;
			step(bit_cyc);
		end
	endtask
	// bits[0] goes first; start and stop levels come from the caller
	task automatic send_frame(input int bit_cyc, input int nbits, input logic [10:0] bits);
		drv_oe = 1'b1;
		for (int i = 0; i < nbits; i++) begin
			drv_val = bits[i];
			step(bit_cyc);
		end
		drv_oe = 1'b0;
	endtask
	// ------------------------------------------------------------
	// shift-register device
	// ------------------------------------------------------------
	// data taken at each rising shift clock; period is rise to rise
	task automatic shift_get(output logic [7:0] data, output int period);
		int w1;
		int w2;
		for (int i = 0; i < 8; i++) begin
			wait_txd(1'b0, 100, w1);
			wait_txd(1'b1, 100, w2);
			data[i] = line;
			period = w1 + w2;
		end
	endtask
	// next bit presented on each falling shift clock, held past the rise
	task automatic shift_put(input logic [7:0] data);
		int w;
		drv_oe = 1'b1;
		for (int i = 0; i < 8; i++) begin
			wait_txd(1'b0, 100, w);
			drv_val = data[i];
			wait_txd(1'b1, 100, w);
		end
		// the port samples one cycle after the rise, so the last bit stays a little longer
		step(1);
		drv_oe = 1'b0;
	endtask
endmodule

// [verification/test_serial_port.sv]
// self-checking bench for the serial port against a remote serial peer
`timescale 1ns/1ps
module test_serial_port;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic mclk, reset_n, clk_en, osc_tick, t1_overflow, rx_enable, baud_double_select;
	logic brg_select, addr_match_en, double_buffer_en, break_reset_en, tx_ninth_bit, tx_valid;
	logic shift_rx_start, framing_error_clear, break_cause_clear;
	logic [1:0] mode, div_cnt;
	logic [7:0] baud_divisor_high, baud_divisor_low, own_addr, tx_data, rx_data, sh_data;
	logic tx_ready, tx_done, rx_ninth_bit, rx_frame_err, rx_valid, framing_error;
	logic reset_cause_break, break_reset_req, rxd_in, rxd_out, rxd_oe, txd_out;
	logic drv_oe, drv_val, brk_seen, got_v;
	int errors, samples_checked, done_cnt, sh_per;
	// pull-up on the data line: reads high when nobody drives it
	assign rxd_in = rxd_oe ? rxd_out : (drv_oe ? drv_val : 1'b1);
	serial_port dut_u (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .osc_tick(osc_tick),
		.t1_overflow(t1_overflow), .mode(mode), .rx_enable(rx_enable),
		.baud_double_select(baud_double_select), .brg_select(brg_select),
		.baud_divisor_high(baud_divisor_high), .baud_divisor_low(baud_divisor_low),
		.addr_match_en(addr_match_en), .own_addr(own_addr), .double_buffer_en(double_buffer_en),
		.break_reset_en(break_reset_en), .tx_data(tx_data), .tx_ninth_bit(tx_ninth_bit),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_done(tx_done),
		.shift_rx_start(shift_rx_start), .rx_data(rx_data), .rx_ninth_bit(rx_ninth_bit),
		.rx_frame_err(rx_frame_err), .rx_valid(rx_valid),
		.framing_error_clear(framing_error_clear), .framing_error(framing_error),
		.break_cause_clear(break_cause_clear), .reset_cause_break(reset_cause_break),
		.break_reset_req(break_reset_req), .rxd_in(rxd_in), .rxd_out(rxd_out),
		.rxd_oe(rxd_oe), .txd_out(txd_out));
	serial_peer peer_u (.mclk(mclk), .txd(txd_out), .line(rxd_in), .drv_oe(drv_oe),
		.drv_val(drv_val));
	// ------------------------------------------------------------
	// clock, rate sources, monitors
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// oscillator tick at half the clock so a generator fed from mclk shows up
	always @(posedge mclk) begin
		#1;
		div_cnt = div_cnt + 2'h1;
		osc_tick = div_cnt[0];
		t1_overflow = (div_cnt == 2'h3);
	end
	// pulses are one cycle wide, so each edge sees each pulse once
	always @(posedge mclk) begin
		if (tx_done === 1'b1) done_cnt++;
		if (break_reset_req === 1'b1) brk_seen = 1'b1;
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cfg(input logic [1:0] m, input logic dbl, input logic brg);
		@(posedge mclk);
		#1;
		mode = m;
		baud_double_select = dbl;
		brg_select = brg;
	endtask
	// valid is held until an edge where ready was seen high beforehand
	task automatic send_tx(input logic [7:0] d, input logic n9);
		@(posedge mclk);
		#1;
		tx_data = d;
		tx_ninth_bit = n9;
		tx_valid = 1'b1;
		for (int w = 0; w < 3000 && tx_ready !== 1'b1; w++) begin
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		#1;
		tx_valid = 1'b0;
	endtask
	task automatic tx_check(input int bc, input logic [7:0] d, input logic n9, input int nb);
		logic [10:0] got;
		logic [10:0] exp;
		exp = (nb == 11) ? {1'b1, n9, d, 1'b0} : {2'b11, d, 1'b0};
		fork
			send_tx(d, n9);
			peer_u.get_frame(bc, nb, got);
		join
		check("tx frame", 16'(exp), 16'(got));
	endtask
	task automatic wait_rx(input int lim);
		got_v = 1'b0;
		for (int w = 0; w < lim && !got_v; w++) begin
			@(posedge mclk);
			#2;
			got_v = (rx_valid === 1'b1);
		end
	endtask
	// exp packs ninth bit, frame error flag and data
	task automatic rx_check(input int bc, input int nb, input logic [10:0] bits,
		input logic ev, input logic [9:0] exp);
		fork
			peer_u.send_frame(bc, nb, bits);
			wait_rx(nb * bc);
		join
		check("rx valid", 16'(ev), 16'(got_v));
		if (ev) check("rx result", 16'(exp), 16'({rx_ninth_bit, rx_frame_err, rx_data}));
	endtask
	task automatic clears();
		@(posedge mclk);
		#1;
		framing_error_clear = 1'b1;
		break_cause_clear = 1'b1;
		@(posedge mclk);
		#1;
		framing_error_clear = 1'b0;
		break_cause_clear = 1'b0;
		@(posedge mclk);
		#2;
	endtask
	task automatic summarize();
		if (errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{clk_en, rx_enable, break_reset_en} = 3'h7;
		{osc_tick, t1_overflow, baud_double_select, brg_select, addr_match_en} = 5'h00;
		{double_buffer_en, tx_ninth_bit, tx_valid, shift_rx_start} = 4'h0;
		{framing_error_clear, break_cause_clear, brk_seen, got_v} = 4'h0;
		{mode, div_cnt} = 4'h0;
		{baud_divisor_high, baud_divisor_low} = 16'h0003;
		own_addr = 8'h55;
		tx_data = 8'h00;
		{errors, samples_checked, done_cnt, sh_per} = 128'h0;
		reset_n = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		#1;
		check("reset outputs", 16'h000C, 16'({txd_out, tx_ready, rx_valid, framing_error}));
		// transmit at every rate source
		cfg(serial_port_pkg::MODE_9FIX, 1'b1, 1'b0);
		tx_check(16, 8'h96, 1'b1, 11);
		// double buffering: ready comes back while the shifter is still busy
		double_buffer_en = 1'b1;
		send_tx(8'hA1, 1'b0);
		@(posedge mclk);
		#1;
		check("ready while sending", 16'h0001, 16'(tx_ready));
		double_buffer_en = 1'b0;
		#1;
		check("ready unbuffered", 16'h0000, 16'(tx_ready));
		repeat (200) @(posedge mclk);
		cfg(serial_port_pkg::MODE_9FIX, 1'b0, 1'b0);
		tx_check(32, 8'h3A, 1'b0, 11);
		cfg(serial_port_pkg::MODE_8BIT, 1'b0, 1'b1);
		tx_check(128, 8'hC5, 1'b0, 10);
		cfg(serial_port_pkg::MODE_9VAR, 1'b1, 1'b0);
		tx_check(128, 8'h5B, 1'b1, 11);
		// receive in the 8-bit mode from timer overflow, good and bad stop
		cfg(serial_port_pkg::MODE_8BIT, 1'b0, 1'b0);
		rx_check(64, 10, {2'b11, 8'h3C, 1'b0}, 1'b1, {2'b10, 8'h3C});
		rx_check(64, 10, {2'b10, 8'h81, 1'b0}, 1'b1, {2'b01, 8'h81});
		check("framing sticky", 16'h0001, 16'(framing_error));
		clears();
		check("framing cleared", 16'h0000, 16'(framing_error));
		// 9-bit receive: ninth bit kept, stop discarded
		cfg(serial_port_pkg::MODE_9FIX, 1'b1, 1'b0);
		rx_check(16, 11, {2'b11, 8'hE7, 1'b0}, 1'b1, {2'b10, 8'hE7});
		rx_check(16, 11, {2'b10, 8'h4D, 1'b0}, 1'b1, {2'b00, 8'h4D});
		// address recognition drops a foreign address, delivers its own
		addr_match_en = 1'b1;
		rx_check(16, 11, {2'b11, 8'h12, 1'b0}, 1'b0, 10'h000);
		rx_check(16, 11, {2'b11, 8'h55, 1'b0}, 1'b1, {2'b10, 8'h55});
		addr_match_en = 1'b0;
		// break: line low through a whole frame including the stop position
		cfg(serial_port_pkg::MODE_8BIT, 1'b0, 1'b0);
		peer_u.send_frame(64, 10, 11'h000);
		repeat (1300) @(posedge mclk);
		#2;
		check("break request", 16'h0003, 16'({brk_seen, reset_cause_break}));
		clears();
		check("break cleared", 16'h0000, 16'(reset_cause_break));
		// shift mode out then in
		cfg(serial_port_pkg::MODE_SHIFT, 1'b0, 1'b1);
		fork
			send_tx(8'hB4, 1'b0);
			peer_u.shift_get(sh_data, sh_per);
		join
		check("shift out", 16'h00B4, 16'(sh_data));
		check("shift period", 16'h0010, 16'(sh_per));
		repeat (20) @(posedge mclk);
		#1;
		fork
			begin
				@(posedge mclk);
				#1;
				shift_rx_start = 1'b1;
				@(posedge mclk);
				#1;
				shift_rx_start = 1'b0;
				wait_rx(400);
			end
			peer_u.shift_put(8'h6D);
		join
		check("shift in", 16'h016D, 16'({got_v, rx_data}));
		check("tx done count", 16'h0006, 16'(done_cnt));
		summarize();
	end
	// a full run is about 8k cycles; a hang is cut off well past that
	initial begin
		#5000000;
		errors++;
		summarize();
	end
endmodule
